// [dfs_channel_ctrl.sv]
/*
 * dfs_channel_ctrl: one timing channel's operating-state machine,
 * reference qualification and selection, lock detect, and alignment
 * of the output clock and output frame/sync pulse to an input pulse.
 * Assumes alarms and phase error come from logic on clock_i, and the
 * reference clock and pulse are asynchronous pins.
 */
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module dfs_channel_ctrl
	import dfs_pkg::*;
#(
	parameter int NUM_REFS = NUM_REFS_DEF,
	parameter int LOCK_CNT = LOCK_CNT_DEF,
	parameter int ERR_W = CNT_W,
	localparam int IDX_W = (NUM_REFS > 1) ? $clog2(NUM_REFS) : 1,
	localparam int LC_W = $clog2(LOCK_CNT + 1)
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic enable_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	input wire logic associated_input_clock_i,
	input wire logic input_pulse_signal_i,
	input wire logic [NUM_REFS-1:0] ref_alarm_i,
	input wire logic signed [ERR_W-1:0] phase_error_i,
	output logic [NUM_REFS-1:0] ref_qualified_o,
	output logic [IDX_W-1:0] selected_ref_o,
	output logic selected_valid_o,
	output logic [2:0] channel_state_o,
	output logic lock_detect_o,
	output logic aligned_output_clock_o,
	output logic aligned_output_pulse_o
);
	// software registers
	logic [CTL_W-1:0] ctrl_reg; // channel_control_word_two
	logic force_en_reg; // forced reference selection
	logic [IDX_W-1:0] force_idx_reg;
	logic [CNT_W-1:0] fdiv_reg; // channel_frame_divider
	logic [CNT_W-1:0] cdiv_reg; // output clock half period
	logic [1:0] pwid_reg; // output pulse width select
	logic [ERR_W-1:0] lthr_reg; // lock threshold
	logic [CNT_W-1:0] qtim_reg; // qualification period

	// write decode
	// one strobe per cycle; unmapped offsets match nothing and are dropped
	wire wr_ctrl = reg_write_i && (reg_addr_i == OFS_CTRL);
	wire wr_force = reg_write_i && (reg_addr_i == OFS_FORCE);
	wire wr_fdiv = reg_write_i && (reg_addr_i == OFS_FDIV);
	wire wr_cdiv = reg_write_i && (reg_addr_i == OFS_CDIV);
	wire wr_pwid = reg_write_i && (reg_addr_i == OFS_PWID);
	wire wr_lthr = reg_write_i && (reg_addr_i == OFS_LTHR);
	wire wr_qtim = reg_write_i && (reg_addr_i == OFS_QTIM);

	// control field decode
	wire dfs_mode_e mode_w = dfs_mode_e'(ctrl_reg[CTL_MODE_LSB +: 2]);
	wire sync_mode_w = ctrl_reg[CTL_SYNC_BIT]; // sync instead of frame
	wire fall_sel_w = ctrl_reg[CTL_FALL_BIT]; // pulse edge select
	wire frame_alignment_enable = ctrl_reg[CTL_ALIGN_BIT];
	wire revertive_w = ctrl_reg[CTL_REVERT_BIT];

	// register writes
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ctrl_reg <= CTRL_RST;
			force_en_reg <= 1'b0;
			force_idx_reg <= '0;
			fdiv_reg <= FDIV_RST;
			cdiv_reg <= CDIV_RST;
			pwid_reg <= PWID_RST;
			lthr_reg <= ERR_W'(LTHR_RST);
			qtim_reg <= QTIM_RST;
		end else if (enable_i) begin
			if (wr_ctrl) ctrl_reg <= reg_wdata_i[CTL_W-1:0];
			if (wr_force) force_en_reg <= reg_wdata_i[FRC_EN_BIT];
			if (wr_force) force_idx_reg <= reg_wdata_i[IDX_W-1:0];
			if (wr_fdiv) fdiv_reg <= reg_wdata_i[CNT_W-1:0];
			if (wr_cdiv) cdiv_reg <= reg_wdata_i[CNT_W-1:0];
			if (wr_pwid) pwid_reg <= reg_wdata_i[1:0];
			if (wr_lthr) lthr_reg <= reg_wdata_i[ERR_W-1:0];
			if (wr_qtim) qtim_reg <= reg_wdata_i[CNT_W-1:0];
		end
	end

	// ---- reference qualification ----
	logic [CNT_W-1:0] qcnt_reg [NUM_REFS]; // clear-time counters
	logic [NUM_REFS-1:0] qual_reg; // qualified references

	// an alarm drops a reference at once; coming back takes the full timer
	// the counter stops once qualified, so a long clear spell cannot wrap it
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			qual_reg <= '0;
			for (int i = 0; i < NUM_REFS; i++) qcnt_reg[i] <= '0;
		end else if (enable_i) begin
			for (int i = 0; i < NUM_REFS; i++) begin
				if (ref_alarm_i[i]) begin
					qcnt_reg[i] <= '0; // any alarm restarts the wait
					qual_reg[i] <= 1'b0;
				end else if (!qual_reg[i]) begin
					if (qcnt_reg[i] >= qtim_reg) qual_reg[i] <= 1'b1;
					else qcnt_reg[i] <= qcnt_reg[i] + 16'h0001;
				end
			end
		end
	end

	// ---- reference selection ----
	// a forced pick beats revertive choice; a loss falls back to the best one
	logic [IDX_W-1:0] sel_reg; // selected reference
	logic sel_valid_reg;

	// lowest index wins; index stands for priority here
	// limitation: no priority table, so equal priorities cannot be expressed
	function automatic logic [IDX_W-1:0] first_set(input logic [NUM_REFS-1:0] v);
		first_set = '0;
		for (int i = NUM_REFS - 1; i >= 0; i--) begin
			if (v[i]) first_set = IDX_W'(i);
		end
	endfunction : first_set

	wire any_qual_w = |qual_reg;
	wire [IDX_W-1:0] best_w = first_set(qual_reg);
	wire cur_ok_w = sel_valid_reg && qual_reg[sel_reg];
	wire cur_lost_w = sel_valid_reg && !qual_reg[sel_reg];
	wire force_go_w = force_en_reg && qual_reg[force_idx_reg] && (force_idx_reg != sel_reg);
	wire revert_go_w = revertive_w && cur_ok_w && (best_w < sel_reg) && !force_en_reg;
	wire lost_go_w = cur_lost_w && any_qual_w && !force_en_reg;
	// move from the selected reference to another, by force, reversion or after a loss; not the first pick
	wire switch_w = sel_valid_reg && (force_go_w || revert_go_w || lost_go_w);
	wire pick_w = !sel_valid_reg && any_qual_w;
	wire [IDX_W-1:0] target_w = force_go_w ? force_idx_reg : best_w;

	// selection update
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			sel_reg <= '0;
			sel_valid_reg <= 1'b0;
		end else if (enable_i) begin
			if (switch_w || pick_w) begin
				sel_reg <= target_w;
				sel_valid_reg <= 1'b1;
			end else if (cur_lost_w) begin
				sel_valid_reg <= 1'b0; // no move: nothing else qualified, or a force blocks the fallback
			end
		end
	end

	// ---- lock detector ----
	// limitation: a run of good cycles, not a filtered phase estimate
	logic [LC_W-1:0] lcnt_reg; // cycles within threshold
	// most negative error wraps; threshold never reaches it in practice
	wire [ERR_W-1:0] err_mag_w = phase_error_i[ERR_W-1] ? ERR_W'(-phase_error_i) :
		ERR_W'(phase_error_i);
	wire in_thr_w = (err_mag_w <= lthr_reg);
	wire locked_w = (lcnt_reg == LC_W'(LOCK_CNT));

	// a switch restarts the count, lock belongs to one reference
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			lcnt_reg <= '0;
		end else if (enable_i) begin
			if (!cur_ok_w || switch_w || !in_thr_w) lcnt_reg <= '0;
			else if (!locked_w) lcnt_reg <= lcnt_reg + LC_W'(1);
		end
	end

	// ---- operating state machine ----
	dfs_state_e state_reg;
	dfs_state_e state_next;
	wire gone_w = cur_lost_w && !any_qual_w; // selected lost, none left

	// next state; forced modes override the automatic choice
	// leaving a forced mode resumes automatic control from the forced state
	always_comb begin
		state_next = state_reg;
		case (mode_w)
			MODE_FORCE_LOCK: state_next = locked_state;
			MODE_FORCE_FREE: state_next = free_run_state;
			MODE_FORCE_HOLD: state_next = holdover_state;
			default: begin
				case (state_reg)
					free_run_state: begin
						if (cur_ok_w) state_next = lock_acquisition_state;
					end
					lock_acquisition_state: begin
						if (gone_w) state_next = free_run_state;
						else if (locked_w && !switch_w) state_next = locked_state;
					end
					locked_state: begin
						if (gone_w) state_next = holdover_state;
						else if (switch_w) state_next = lock_recovery_state;
					end
					holdover_state: begin
						if (any_qual_w) state_next = lock_recovery_state;
					end
					lock_recovery_state: begin
						if (gone_w) state_next = holdover_state;
						else if (locked_w && !switch_w) state_next = locked_state;
					end
					default: state_next = free_run_state;
				endcase
			end
		endcase
	end

	// state register
	always_ff @(posedge clock_i) begin
		if (!resetn_i) state_reg <= free_run_state;
		else if (enable_i) state_reg <= state_next;
	end

	// ---- input pin synchronisers ----
	// bit 0 associated_input_clock, bit 1 input_pulse_signal
	logic [1:0] sy1_reg; // first stage, read only by sy2
	logic [1:0] sy2_reg;
	logic [1:0] sy3_reg;
	logic [1:0] filt_reg; // accepted level
	wire [1:0] agree_w = ~(sy2_reg ^ sy3_reg);
	wire [1:0] filt_next = (agree_w & sy2_reg) | (~agree_w & filt_reg);
	wire [1:0] rise_w = filt_next & ~filt_reg;
	wire [1:0] fall_w = ~filt_next & filt_reg;

	// three stages, a change counts once stages two and three agree
	// trade-off: one extra cycle of latency buys rejection of one-sample glitches
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			sy1_reg <= 2'h0;
			sy2_reg <= 2'h0;
			sy3_reg <= 2'h0;
			filt_reg <= 2'h0;
		end else if (enable_i) begin
			sy1_reg <= {input_pulse_signal_i, associated_input_clock_i};
			sy2_reg <= sy1_reg;
			sy3_reg <= sy2_reg;
			filt_reg <= filt_next;
		end
	end

	// ---- alignment event ----
	// the sampled clock only covers slow references; at full rate the
	// sync path still works since it needs no clock edge
	logic armed_reg; // frame edge seen, waiting for clock rise
	wire pulse_edge_w = fall_sel_w ? fall_w[1] : rise_w[1];
	wire clk_rise_w = rise_w[0];
	wire frame_align_w = armed_reg && clk_rise_w;
	wire align_w = frame_alignment_enable &&
		(sync_mode_w ? pulse_edge_w : frame_align_w);

	// arm on the frame edge; the rise in the same cycle is not the next one
	always_ff @(posedge clock_i) begin
		if (!resetn_i) armed_reg <= 1'b0;
		else if (enable_i) begin
			if (sync_mode_w || !frame_alignment_enable) armed_reg <= 1'b0;
			else if (pulse_edge_w) armed_reg <= 1'b1;
			else if (clk_rise_w) armed_reg <= 1'b0;
		end
	end

	// ---- output clock and pulse ----
	logic [CNT_W-1:0] ocnt_reg; // half-period counter
	logic [CNT_W-1:0] fcnt_reg; // output clock periods in frame
	logic [4:0] pleft_reg; // pulse ticks remaining
	wire [CNT_W-1:0] half_w = dfs_nz(cdiv_reg);
	wire [CNT_W-1:0] frame_w = dfs_nz(fdiv_reg);
	wire tick_w = (ocnt_reg >= half_w - 16'h0001);
	wire orise_w = tick_w && !aligned_output_clock_o;
	wire fwrap_w = orise_w && (fcnt_reg >= frame_w - 16'h0001);

	// alignment restarts both dividers with a rising clock and a pulse
	// zero dividers read as one so a cleared register cannot stall the counters
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ocnt_reg <= '0;
			fcnt_reg <= '0;
			pleft_reg <= 5'h00;
			aligned_output_clock_o <= 1'b0;
			aligned_output_pulse_o <= 1'b0;
		end else if (enable_i) begin
			if (align_w) begin
				ocnt_reg <= '0;
				fcnt_reg <= '0;
				aligned_output_clock_o <= 1'b1;
				aligned_output_pulse_o <= 1'b1;
				pleft_reg <= dfs_pulse_ticks(pwid_reg) - 5'h01;
			end else begin
				ocnt_reg <= tick_w ? '0 : ocnt_reg + 16'h0001;
				if (tick_w) aligned_output_clock_o <= !aligned_output_clock_o;
				if (fwrap_w) fcnt_reg <= '0;
				else if (orise_w) fcnt_reg <= fcnt_reg + 16'h0001;
				if (fwrap_w) begin
					aligned_output_pulse_o <= 1'b1;
					pleft_reg <= dfs_pulse_ticks(pwid_reg) - 5'h01;
				end else if (tick_w) begin
					if (pleft_reg == 5'h00) aligned_output_pulse_o <= 1'b0;
					else pleft_reg <= pleft_reg - 5'h01;
				end
			end
		end
	end

	// ---- status outputs and read port ----
	logic [DATA_W-1:0] rd_mux_w;
	wire [DATA_W-1:0] stat_w = (DATA_W'(state_reg) << STAT_STATE_LSB) |
		(DATA_W'(locked_w) << STAT_LOCK_BIT) |
		(DATA_W'(sel_valid_reg) << STAT_SELV_BIT) |
		(DATA_W'(sel_reg) << STAT_SEL_LSB) |
		(DATA_W'(qual_reg) << STAT_QUAL_LSB);

	// read select; unmapped offsets read zero
	always_comb begin
		case (reg_addr_i)
			OFS_CTRL: rd_mux_w = DATA_W'(ctrl_reg);
			OFS_FORCE: rd_mux_w = (DATA_W'(force_en_reg) << FRC_EN_BIT) |
				DATA_W'(force_idx_reg);
			OFS_FDIV: rd_mux_w = DATA_W'(fdiv_reg);
			OFS_CDIV: rd_mux_w = DATA_W'(cdiv_reg);
			OFS_PWID: rd_mux_w = DATA_W'(pwid_reg);
			OFS_LTHR: rd_mux_w = DATA_W'(lthr_reg);
			OFS_QTIM: rd_mux_w = DATA_W'(qtim_reg);
			OFS_STAT: rd_mux_w = stat_w;
			default: rd_mux_w = '0;
		endcase
	end

	// read data stands one cycle only; status outputs registered
	// the state output takes the next state so it matches the state register
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= '0;
			ref_qualified_o <= '0;
			selected_ref_o <= '0;
			selected_valid_o <= 1'b0;
			channel_state_o <= 3'h0;
			lock_detect_o <= 1'b0;
		end else if (enable_i) begin
			reg_rdata_o <= reg_read_i ? rd_mux_w : '0;
			ref_qualified_o <= qual_reg;
			selected_ref_o <= sel_reg;
			selected_valid_o <= sel_valid_reg;
			channel_state_o <= 3'(state_next);
			lock_detect_o <= locked_w;
		end
	end
endmodule : dfs_channel_ctrl

// [dfs_channel_ctrl_chk.sv]
/*
 * dfs_channel_ctrl_chk: port-level checker for the channel controller.
 * Assumes enable_i high whenever the channel state is of interest.
 */
`timescale 1ns/1ps
module dfs_channel_ctrl_chk
	import dfs_pkg::*;
#(
	parameter int NUM_REFS = NUM_REFS_DEF,
	localparam int IDX_W = (NUM_REFS > 1) ? $clog2(NUM_REFS) : 1
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic enable_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic [NUM_REFS-1:0] ref_alarm_i,
	input wire logic [NUM_REFS-1:0] ref_qualified_o,
	input wire logic [IDX_W-1:0] selected_ref_o,
	input wire logic selected_valid_o,
	input wire logic [2:0] channel_state_o,
	input wire logic lock_detect_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	logic [1:0] mode_q; // shadow of the mode field
	logic wr_q; // a mode write landed last edge
	wire ctrl_wr = reg_write_i && enable_i && (reg_addr_i == OFS_CTRL);
	wire auto_m = (mode_q == 2'h0) && !wr_q; // settled automatic mode
	wire [2:0] forced_st = (mode_q == 2'h1) ? 3'h2 : (mode_q == 2'h2) ? 3'h0 : 3'h3;
	wire sel_ok = selected_valid_o && ref_qualified_o[selected_ref_o];
	wire none_q = (ref_qualified_o == '0);
	// track the mode so that the state checks know which rules apply
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			mode_q <= 2'h0;
			wr_q <= 1'b0;
		end else if (enable_i) begin
			wr_q <= ctrl_wr;
			if (ctrl_wr) begin
				mode_q <= reg_wdata_i[1:0];
			end
		end
	end
	property p_reset_free;
		$rose(resetn_i) |-> (channel_state_o == 3'h0) && !lock_detect_o;
	endproperty
	a_reset_free: assert property (p_reset_free) else $error("state not free-run after reset");
	property p_fr_acq;
		(auto_m && $past(channel_state_o) == 3'h0 && sel_ok)
			|-> ##[0:1] (channel_state_o == 3'h1);
	endproperty
	a_fr_acq: assert property (p_fr_acq) else $error("no acquisition on valid ref");
	property p_acq_free;
		(auto_m && $past(channel_state_o) == 3'h1 && none_q)
			|-> ##[0:2] (channel_state_o == 3'h0);
	endproperty
	a_acq_free: assert property (p_acq_free) else $error("acquisition kept with no ref");
	property p_lock_enter;
		(auto_m && ($past(channel_state_o) == 3'h1 || $past(channel_state_o) == 3'h4) &&
			lock_detect_o) |-> ##[0:2] (channel_state_o == 3'h2);
	endproperty
	a_lock_enter: assert property (p_lock_enter) else $error("lock did not enter locked");
	property p_to_hold;
		(auto_m && ($past(channel_state_o) == 3'h2 || $past(channel_state_o) == 3'h4) &&
			none_q) |-> ##[0:2] (channel_state_o == 3'h3);
	endproperty
	a_to_hold: assert property (p_to_hold) else $error("no holdover on loss of refs");
	property p_ho_rec;
		(auto_m && $past(channel_state_o) == 3'h3 && !none_q)
			|-> ##[0:3] (channel_state_o == 3'h4);
	endproperty
	a_ho_rec: assert property (p_ho_rec) else $error("no recovery from holdover");
	property p_forced;
		(mode_q != 2'h0 && !wr_q) |-> (channel_state_o == forced_st);
	endproperty
	a_forced: assert property (p_forced) else $error("forced mode not obeyed");
	property p_switch_rec;
		(auto_m && $past(channel_state_o, 2) == 3'h2 && selected_valid_o &&
			$changed(selected_ref_o)) |-> ##[0:2] (channel_state_o == 3'h4);
	endproperty
	a_switch_rec: assert property (p_switch_rec) else $error("switch kept locked state");
	property p_alarm_drop;
		ref_alarm_i[0] |-> ##[1:2] !ref_qualified_o[0];
	endproperty
	a_alarm_drop: assert property (p_alarm_drop) else $error("alarmed ref still qualified");
	property p_rdata_idle;
		!$past(reg_read_i) |-> (reg_rdata_o == '0);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
	c_locked: cover property (channel_state_o == 3'h2);
	c_hold: cover property (auto_m && channel_state_o == 3'h3);
	c_rec: cover property (channel_state_o == 3'h4);
endmodule : dfs_channel_ctrl_chk

// [dfs_channel_ctrl_tb_top.sv]
/*
 * dfs_channel_ctrl_tb_top: self-checking bench for the channel controller.
 * Assumes the reference source model and the bound checker.
 */
`timescale 1ns/1ps
module dfs_channel_ctrl_tb_top;
	import dfs_pkg::*;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic enable_i = 1'b1; // low only in the freeze test
	logic [ADDR_W-1:0] reg_addr_i = '0;
	logic [DATA_W-1:0] reg_wdata_i = '0;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [NUM_REFS_DEF-1:0] ref_alarm_i = 4'hf; // all refs alarmed
	logic signed [CNT_W-1:0] phase_error_i = 16'sh0100; // beyond threshold
	logic pulse_req = 1'b0;
	wire [DATA_W-1:0] reg_rdata_o;
	wire assoc_clk, pulse_pin, sel_valid, lock_det, out_clk, out_pulse;
	wire [NUM_REFS_DEF-1:0] qual;
	wire [1:0] sel_ref;
	wire [2:0] st;
	int n_fail = 0;
	int checks_done = 0;
	logic [31:0] d;
	int n;
	int len;
	logic [31:0] rst_v [7] = '{32'h0, 32'h0, 32'h0a, 32'h4, 32'h0, 32'h10, 32'h100};
	logic [5:0] ctl_v [5] = '{6'h14, 6'h10, 6'h1c, 6'h18, 6'h04};
	int lo_v [5] = '{2, 6, 10, 14, 30};
	dfs_channel_ctrl uut (.clock_i(clock_i), .resetn_i(resetn_i), .enable_i(enable_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
		.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
		.associated_input_clock_i(assoc_clk), .input_pulse_signal_i(pulse_pin),
		.ref_alarm_i(ref_alarm_i), .phase_error_i(phase_error_i), .ref_qualified_o(qual),
		.selected_ref_o(sel_ref), .selected_valid_o(sel_valid), .channel_state_o(st),
		.lock_detect_o(lock_det), .aligned_output_clock_o(out_clk),
		.aligned_output_pulse_o(out_pulse));
	dfs_ref_source src (.pulse_req_i(pulse_req), .associated_input_clock_o(assoc_clk),
		.input_pulse_signal_o(pulse_pin));
	// 100 MHz system clock
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		reg_write_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
	endtask : wr
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock_i);
		reg_read_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_read_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask : rd
	// bounded wait for a state, then compare
	task automatic wait_st(input logic [2:0] s, input int lim);
		int i;
		i = 0;
		while (st !== s && i < lim) begin
			@(posedge clock_i);
			#1 i++;
		end
		chk({29'h0, st}, {29'h0, s});
	endtask : wait_st
	// send one pulse, count cycles from pin rise to output pulse rise
	task automatic align_meas(input logic [5:0] ctl, output int dl);
		wr(OFS_CTRL, {26'h0, ctl});
		repeat (80) @(posedge clock_i);
		pulse_req <= 1'b1;
		// wait from the request edge itself so a quick pin rise is not missed
		@(posedge pulse_pin);
		dl = 0;
		while (out_pulse !== 1'b1 && dl < 30) begin
			@(posedge clock_i);
			pulse_req <= 1'b0;
			#1 dl++;
		end
	endtask : align_meas
	// watchdog well past the expected run length
	initial begin
		#500000;
		n_fail++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		#1 chk({29'h0, st}, 32'h0);
		for (int i = 0; i < 7; i++) begin
			rd(8'(4 * i), d);
			chk(d, rst_v[i]);
		end
		rd(8'h20, d);
		chk(d, 32'h0);
		// qualification timer and automatic states
		wr(OFS_QTIM, 32'h4);
		rd(OFS_QTIM, d);
		chk(d, 32'h4);
		ref_alarm_i <= 4'hd;
		repeat (3) @(posedge clock_i);
		#1 chk({31'h0, qual[1]}, 32'h0);
		n = 0;
		while (qual[1] !== 1'b1 && n < 10) begin
			@(posedge clock_i);
			#1 n++;
		end
		chk({31'h0, qual[1]}, 32'h1);
		wait_st(lock_acquisition_state, 10);
		repeat (40) @(posedge clock_i);
		#1 chk({29'h0, st}, 32'h1);
		phase_error_i <= 16'sh0008;
		wait_st(locked_state, LOCK_CNT_DEF + 10);
		wr(OFS_CTRL, 32'h20);
		ref_alarm_i <= 4'h8;
		wait_st(lock_recovery_state, 20);
		rd(OFS_STAT, d);
		chk({30'h0, d[9:8]}, 32'h0);
		wait_st(locked_state, 40);
		wr(OFS_FORCE, 32'h102);
		wait_st(lock_recovery_state, 10);
		rd(OFS_STAT, d);
		chk({30'h0, d[9:8]}, 32'h2);
		wait_st(locked_state, 40);
		ref_alarm_i <= 4'hf;
		wait_st(holdover_state, 10);
		wr(OFS_FORCE, 32'h0);
		ref_alarm_i <= 4'hb;
		wait_st(lock_recovery_state, 20);
		ref_alarm_i <= 4'hf;
		wait_st(holdover_state, 10);
		// forced modes, then back to automatic
		wr(OFS_CTRL, 32'h3);
		ref_alarm_i <= 4'h0;
		repeat (40) @(posedge clock_i);
		#1 chk({29'h0, st}, 32'h3);
		wr(OFS_CTRL, 32'h1);
		wait_st(locked_state, 3);
		phase_error_i <= 16'sh0100;
		wr(OFS_CTRL, 32'h2);
		wait_st(free_run_state, 3);
		wr(OFS_CTRL, 32'h0);
		wait_st(lock_acquisition_state, 5);
		ref_alarm_i <= 4'hf;
		wait_st(free_run_state, 5);
		// free-running output pulse rate
		wr(OFS_FDIV, 32'h2);
		@(posedge out_pulse);
		n = 0;
		@(posedge clock_i);
		while (out_pulse !== 1'b0 || n < 2) begin
			@(posedge clock_i);
			n++;
		end
		while (out_pulse !== 1'b1 && n < 40) begin
			@(posedge clock_i);
			n++;
		end
		chk(32'(n), 32'd16);
		// clock enable low freezes the output dividers
		@(posedge clock_i);
		enable_i <= 1'b0;
		@(posedge clock_i);
		#1 d = {30'h0, out_clk, out_pulse};
		repeat (20) @(posedge clock_i);
		#1 chk({30'h0, out_clk, out_pulse}, d);
		@(posedge clock_i);
		enable_i <= 1'b1;
		// alignment edge per mode and pulse widths
		wr(OFS_FDIV, 32'hffff);
		for (int i = 0; i < 5; i++) begin
			align_meas(ctl_v[i], n);
			chk({31'h0, n >= lo_v[i] && n <= lo_v[i] + 4}, 32'h1);
			if (i < 4) chk({31'h0, out_clk}, 32'h1);
		end
		for (int p = 0; p < 4; p++) begin
			wr(OFS_PWID, 32'(p));
			align_meas(6'h14, n);
			len = 0;
			while (out_pulse === 1'b1 && len < 100) begin
				@(posedge clock_i);
				#1 len++;
			end
			chk({31'h0, len >= (8 << p) - 1 && len <= (8 << p) + 1}, 32'h1);
		end
		report_and_stop();
	end
endmodule : dfs_channel_ctrl_tb_top
bind dfs_channel_ctrl dfs_channel_ctrl_chk #(.NUM_REFS(NUM_REFS)) chk_i (.clock_i(clock_i),
	.resetn_i(resetn_i), .enable_i(enable_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
	.reg_rdata_o(reg_rdata_o), .ref_alarm_i(ref_alarm_i), .ref_qualified_o(ref_qualified_o),
	.selected_ref_o(selected_ref_o), .selected_valid_o(selected_valid_o),
	.channel_state_o(channel_state_o), .lock_detect_o(lock_detect_o));

// [dfs_pkg.sv]
/*
 * dfs_pkg: constants, register map and types for the channel state
 * and frame/sync alignment controller.
 * Assumes a 32-bit register port with byte offsets on word boundaries.
 */
package dfs_pkg;
	// register port geometry, reference count, lock count and counter width
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_REFS_DEF = 4;
	localparam int LOCK_CNT_DEF = 16;
	localparam int CNT_W = 16;
	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FORCE = 8'h04;
	localparam logic [7:0] OFS_FDIV = 8'h08;
	localparam logic [7:0] OFS_CDIV = 8'h0c;
	localparam logic [7:0] OFS_PWID = 8'h10;
	localparam logic [7:0] OFS_LTHR = 8'h14;
	localparam logic [7:0] OFS_QTIM = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1c;
	// channel_control_word_two fields, then the force register enable bit
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_SYNC_BIT = 2;
	localparam int CTL_FALL_BIT = 3;
	localparam int CTL_ALIGN_BIT = 4;
	localparam int CTL_REVERT_BIT = 5;
	localparam int CTL_W = 6;
	localparam int FRC_EN_BIT = 8;
	// status fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_LOCK_BIT = 4;
	localparam int STAT_SELV_BIT = 5;
	localparam int STAT_SEL_LSB = 8;
	localparam int STAT_QUAL_LSB = 16;
	// reset values
	localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [CNT_W-1:0] FDIV_RST = 16'h000a;
	localparam logic [CNT_W-1:0] CDIV_RST = 16'h0004;
	localparam logic [CNT_W-1:0] LTHR_RST = 16'h0010;
	localparam logic [CNT_W-1:0] QTIM_RST = 16'h0100;
	localparam logic [1:0] PWID_RST = 2'h0;
	// channel_operating_mode encodings
	typedef enum logic [1:0] {
		MODE_AUTO,
		MODE_FORCE_LOCK,
		MODE_FORCE_FREE,
		MODE_FORCE_HOLD
	} dfs_mode_e;
	// automatic state machine states
	typedef enum logic [2:0] {
		free_run_state,
		lock_acquisition_state,
		locked_state,
		holdover_state,
		lock_recovery_state
	} dfs_state_e;
	// pulse width select to half-period ticks of the output clock
	function automatic logic [4:0] dfs_pulse_ticks(input logic [1:0] sel);
		case (sel)
			2'h0: dfs_pulse_ticks = 5'h02;
			2'h1: dfs_pulse_ticks = 5'h04;
			2'h2: dfs_pulse_ticks = 5'h08;
			default: dfs_pulse_ticks = 5'h10;
		endcase
	endfunction : dfs_pulse_ticks
	// divider value with zero read as one
	function automatic logic [CNT_W-1:0] dfs_nz(input logic [CNT_W-1:0] v);
		dfs_nz = (v == 16'h0000) ? 16'h0001 : v;
	endfunction : dfs_nz
endpackage : dfs_pkg

// [dfs_ref_source.sv]
/*
 * dfs_ref_source: behavioural far-side reference, a free-running
 * associated clock and a frame/sync pulse sent on request.
 * Assumes requests are spaced by more than two clock periods.
 */
`timescale 1ns/1ps
module dfs_ref_source #(
	parameter int HALF_NS = 40
) (
	input wire logic pulse_req_i,
	output logic associated_input_clock_o,
	output logic input_pulse_signal_o
);
	// free-running reference, offset so its edges avoid the system edges
	initial begin
		associated_input_clock_o = 1'b0;
		input_pulse_signal_o = 1'b0;
		#3;
		forever #(HALF_NS) associated_input_clock_o = ~associated_input_clock_o;
	end
	// pulse starts and ends on clock falls: integer ratio, one period wide
	always @(posedge pulse_req_i) begin
		@(negedge associated_input_clock_o);
		input_pulse_signal_o = 1'b1;
		@(negedge associated_input_clock_o);
		input_pulse_signal_o = 1'b0;
	end
endmodule : dfs_ref_source
